/* File: rtl/gct_pkg.sv */
// Package of constants for the gated 16-bit counter timer
package gct_pkg;
  localparam int GCT_COUNT_W = 16;
  localparam int GCT_BYTE_W = 8;
  localparam int GCT_PRE_W = 3;
  localparam logic [1:0] GCT_PS_DIV1 = 2'h0;
  localparam logic [1:0] GCT_PS_DIV2 = 2'h1;
  localparam logic [1:0] GCT_PS_DIV4 = 2'h2;
  localparam logic [1:0] GCT_PS_DIV8 = 2'h3;
  localparam logic [15:0] GCT_COUNT_RST = 16'h0000;
  localparam logic [15:0] GCT_COUNT_MAX = 16'hFFFF;
  localparam logic [2:0] GCT_PRE_RST = 3'h0;
  // Instruction clock is the oscillator divided by four
  localparam int GCT_INST_DIV = 4;
  localparam logic [1:0] GCT_INST_DIV_LAST = 2'h3;
  localparam int GCT_SYNC_STAGES = 3;
endpackage : gct_pkg

/* File: rtl/gct_sync.sv */
// Three-stage pin synchroniser; a change counts once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module gct_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin and filtered level
  input wire logic pin,
  output logic level
);
  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic level_reg;
  logic level_next;

  always_comb begin
    stage_next = {stage_reg[1:0], pin};
    level_next = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : level_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= 3'h0;
      level_reg <= 1'b0;
    end else begin
      stage_reg <= stage_next;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;
endmodule : gct_sync
`default_nettype wire

/* File: rtl/gct_timer.sv */
// Gated 16-bit up counter with prescaler, clock select, gate and overflow flag
`timescale 1ns/100ps
`default_nettype none
module gct_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control bits
  input wire logic timer_on,
  input wire logic clock_source_select,
  input wire logic sync_bypass_select,
  input wire logic [1:0] prescale_ratio_field,
  input wire logic gate_enable,
  input wire logic gate_invert,
  input wire logic gate_source_select,
  input wire logic comparator_sync_enable,
  input wire logic sleep_mode,
  // Pins and comparator
  input wire logic external_count_clock_pin,
  input wire logic gate_input_pin,
  input wire logic comparator_out,
  // Software access to the count
  input wire logic write_high,
  input wire logic write_low,
  input wire logic [gct_pkg::GCT_BYTE_W-1:0] write_data,
  output logic [gct_pkg::GCT_BYTE_W-1:0] count_high_byte,
  output logic [gct_pkg::GCT_BYTE_W-1:0] count_low_byte,
  // Overflow flag, its clear and the wake request
  input wire logic overflow_clear,
  output logic overflow_flag,
  output logic wake_request,
  // Time base and synchronised comparator
  output logic [gct_pkg::GCT_COUNT_W-1:0] time_base,
  output logic comparator_gate_signal
);
  import gct_pkg::*;

  logic ext_level;
  logic gate_pin_level;
  logic [1:0] inst_div_reg;
  logic [1:0] inst_div_next;
  logic ext_raw_prev_reg;
  logic ext_raw_prev_next;
  logic ext_sync_prev_reg;
  logic ext_sync_prev_next;
  logic [GCT_PRE_W-1:0] pre_reg;
  logic [GCT_PRE_W-1:0] pre_next;
  logic pre_out_prev_reg;
  logic pre_out_prev_next;
  logic cmp_sync_reg;
  logic cmp_sync_next;
  logic [GCT_COUNT_W-1:0] count_reg;
  logic [GCT_COUNT_W-1:0] count_next;
  logic ovf_reg;
  logic ovf_next;
  logic wake_reg;
  logic wake_next;
  logic src_edge;
  logic pre_out;
  logic count_tick;
  logic gate_src;
  logic gate_ok;
  logic run;
  logic sync_path;
  logic wrap;
  logic any_write;

  gct_sync u_ext_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(external_count_clock_pin),
    .level(ext_level)
  );

  gct_sync u_gate_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(gate_input_pin),
    .level(gate_pin_level)
  );

  // Synchronised path runs only when selected and awake; the raw pin is still
  // sampled once here for edge detection, as the asynchronous path cannot be
  // clockless inside a single-clock design.
  always_comb begin
    sync_path = clock_source_select && !sync_bypass_select && !sleep_mode;
    inst_div_next = (inst_div_reg == GCT_INST_DIV_LAST) ? 2'h0 : inst_div_reg + 2'h1;
    ext_raw_prev_next = external_count_clock_pin;
    ext_sync_prev_next = ext_level;
    if (!clock_source_select) begin
      src_edge = (inst_div_reg == GCT_INST_DIV_LAST);
    end else if (sync_path) begin
      src_edge = ext_level && !ext_sync_prev_reg;
    end else if (sync_bypass_select) begin
      src_edge = external_count_clock_pin && !ext_raw_prev_reg;
    end else begin
      src_edge = 1'b0;
    end
  end

  // Prescaler: output is the selected bit of a source-edge counter, count on its rise; at 1:1 every source edge counts
  always_comb begin
    any_write = write_high || write_low;
    pre_next = pre_reg;
    if (any_write) begin
      pre_next = GCT_PRE_RST;
    end else if (src_edge && timer_on) begin
      pre_next = pre_reg + 3'h1;
    end
    unique case (prescale_ratio_field)
      GCT_PS_DIV1: pre_out = src_edge && timer_on;
      GCT_PS_DIV2: pre_out = pre_reg[0];
      GCT_PS_DIV4: pre_out = pre_reg[1];
      GCT_PS_DIV8: pre_out = pre_reg[2];
    endcase
    pre_out_prev_next = any_write ? 1'b0 : pre_out;
  end

  // Comparator resampled on each count clock when its sync bit is set
  always_comb begin
    cmp_sync_next = cmp_sync_reg;
    if (src_edge) begin
      cmp_sync_next = comparator_out;
    end
    comparator_gate_signal = comparator_sync_enable ? cmp_sync_reg : comparator_out;
    gate_src = gate_source_select ? gate_pin_level : comparator_gate_signal;
    gate_ok = !gate_enable || (gate_src ^ gate_invert);
    run = timer_on && gate_ok;
    if (prescale_ratio_field == GCT_PS_DIV1) begin
      count_tick = pre_out;
    end else begin
      count_tick = pre_out && !pre_out_prev_reg;
    end
  end

  // Count, byte writes, overflow flag and wake
  always_comb begin
    count_next = count_reg;
    wrap = 1'b0;
    if (run && count_tick) begin
      count_next = count_reg + 16'h0001;
      wrap = (count_reg == GCT_COUNT_MAX);
    end
    if (write_high) begin
      count_next[15:8] = write_data;
      wrap = 1'b0;
    end
    if (write_low) begin
      count_next[7:0] = write_data;
      wrap = 1'b0;
    end
    ovf_next = ovf_reg;
    if (overflow_clear) begin
      ovf_next = 1'b0;
    end
    if (wrap) begin
      ovf_next = 1'b1;
    end
    wake_next = wrap && sleep_mode && clock_source_select && sync_bypass_select;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inst_div_reg <= 2'h0;
      ext_raw_prev_reg <= 1'b0;
      ext_sync_prev_reg <= 1'b0;
      pre_reg <= GCT_PRE_RST;
      pre_out_prev_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
      count_reg <= GCT_COUNT_RST;
      ovf_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      inst_div_reg <= inst_div_next;
      ext_raw_prev_reg <= ext_raw_prev_next;
      ext_sync_prev_reg <= ext_sync_prev_next;
      pre_reg <= pre_next;
      pre_out_prev_reg <= pre_out_prev_next;
      cmp_sync_reg <= cmp_sync_next;
      count_reg <= count_next;
      ovf_reg <= ovf_next;
      wake_reg <= wake_next;
    end
  end

  assign count_high_byte = count_reg[15:8];
  assign count_low_byte = count_reg[7:0];
  assign time_base = count_reg;
  assign overflow_flag = ovf_reg;
  assign wake_request = wake_reg;

  AST_WRITE_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
    write_high |=> count_reg[15:8] == $past(write_data))
    else $error("high byte write not taken");
  AST_WRITE_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    write_low |=> count_reg[7:0] == $past(write_data))
    else $error("low byte write not taken");
  AST_UP_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(write_high) && !$past(write_low) && count_reg != $past(count_reg)
    |-> count_reg == $past(count_reg) + 16'h0001)
    else $error("count moved other than by one");
  AST_HOLD_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    !timer_on && !write_high && !write_low |=> count_reg == $past(count_reg))
    else $error("count moved while off");
  AST_WRAP_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
    count_reg == GCT_COUNT_MAX ##1 count_reg == GCT_COUNT_RST && !$past(write_high) && !$past(write_low)
    |-> overflow_flag)
    else $error("overflow flag not set on wrap");
  AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    overflow_flag && !overflow_clear |=> overflow_flag)
    else $error("overflow flag dropped without clear");
  AST_PRE_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    (write_high || write_low) |=> pre_reg == GCT_PRE_RST)
    else $error("prescaler not cleared by write");
  AST_INST_RATE: assert property (@(posedge clk) disable iff (!rst_n)
    !clock_source_select && prescale_ratio_field == GCT_PS_DIV1 && run && count_tick
    |=> !count_tick [*3])
    else $error("internal clock ticks faster than one in four");
  AST_WAKE_ASYNC: assert property (@(posedge clk) disable iff (!rst_n)
    wake_request |-> $past(sync_bypass_select) && $past(clock_source_select) && overflow_flag)
    else $error("wake outside asynchronous external mode");
  AST_SLEEP_SYNC: assert property (@(posedge clk) disable iff (!rst_n)
    sleep_mode && clock_source_select && !sync_bypass_select |-> !src_edge)
    else $error("synchronised path counted in sleep");
  AST_TIME_BASE: assert property (@(posedge clk) disable iff (!rst_n)
    time_base == {count_high_byte, count_low_byte})
    else $error("time base differs from count");
  AST_CMP_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    !comparator_sync_enable |-> comparator_gate_signal == comparator_out)
    else $error("unsynchronised comparator not passed through");
endmodule : gct_timer
`default_nettype wire

/* File: verif/gct_src_model.sv */
// Behavioural model of the external count clock pin
`timescale 1ns/100ps
`default_nettype none
module gct_src_model (
  // Clock pin towards the counter
  output logic pin
);
  initial pin = 1'b0;
  // Idles low, so each burst shows a low level before its first rising edge
  task automatic pulses(input int n);
    repeat (n) begin
      #37 pin = 1'b1;
      #37 pin = 1'b0;
    end
  endtask : pulses
endmodule : gct_src_model
`default_nettype wire

/* File: verif/tb_gct_timer.sv */
// Self-checking bench of the gated 16-bit counter timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(act, exp) begin checks_done++; if ((act) !== (exp)) begin failures++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (act), (exp)); end end
module tb_gct_timer;
  import gct_pkg::*;
  logic clk = 0, rst_n = 0, ton = 0, cs = 0, byp = 0, ge = 0, gi = 0, gs = 1, cse = 0, slp = 0;
  logic gpin = 0, cmp = 0, wh = 0, wl = 0, oclr = 0, woke = 0, oflag, wake, cgs;
  logic [1:0] ps = 2'h0;
  logic [7:0] wd = 8'h00, hb, lb;
  logic [15:0] tbase, exp_cnt = 16'h0000, last = 16'h0000, e;
  logic [15:0] q[$];
  int failures = 0, checks_done = 0, cyc = 0, ticks = 0;
  wire logic ext_pin;
  initial forever #2.5 clk = ~clk;
  gct_src_model ext (.pin(ext_pin));
  gct_timer dut (.clk(clk), .rst_n(rst_n), .timer_on(ton), .clock_source_select(cs), .sync_bypass_select(byp),
    .prescale_ratio_field(ps), .gate_enable(ge), .gate_invert(gi), .gate_source_select(gs),
    .comparator_sync_enable(cse), .sleep_mode(slp), .external_count_clock_pin(ext_pin), .gate_input_pin(gpin),
    .comparator_out(cmp), .write_high(wh), .write_low(wl), .write_data(wd), .count_high_byte(hb),
    .count_low_byte(lb), .overflow_clear(oclr), .overflow_flag(oflag), .wake_request(wake), .time_base(tbase),
    .comparator_gate_signal(cgs));
  task automatic final_report;
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (wake) begin
      woke <= 1'b1;
    end
    if (ticks == 20000) begin
      failures++;
      final_report();
    end
  end
  // Any count change takes the oldest expected value; with none queued the count must not move
  always @(negedge clk) begin
    if (rst_n && tbase !== last) begin
      e = (q.size() != 0) ? q.pop_front() : last;
      `CHK(tbase, e)
      `CHK({hb, lb}, e)
      last = tbase;
    end
  end
  task automatic wr(input logic hi, input logic [7:0] v);
    @(negedge clk);
    wh = hi;
    wl = !hi;
    wd = v;
    exp_cnt = hi ? {v, exp_cnt[7:0]} : {exp_cnt[15:8], v};
    if (exp_cnt !== last) q.push_back(exp_cnt);
    @(negedge clk);
    wh = 0;
    wl = 0;
  endtask : wr
  task automatic run(input int n, input int lim);
    for (int i = 0; i < n; i++) begin
      exp_cnt++;
      q.push_back(exp_cnt);
    end
    cyc = 0;
    ton = 1;
    while (q.size() != 0 && cyc < lim) begin
      @(negedge clk);
      cyc++;
    end
    ton = 0;
    `CHK(q.size(), 0)
    q.delete();
  endtask : run
  task automatic hold(input logic on, input int k);
    ton = on;
    repeat (k) @(negedge clk);
    ton = 0;
    `CHK(tbase, exp_cnt)
  endtask : hold
  initial begin
    void'($urandom(69));
    repeat (2) @(negedge clk);
    rst_n = 1;
    `CHK(oflag, 1'b0)
    `CHK(tbase, GCT_COUNT_RST)
    wr(1, 8'($urandom));
    wr(0, 8'($urandom));
    hold(0, 30);
    for (int r = 0; r < 4; r++) begin
      ps = r[1:0];
      wr(0, 8'h00);
      run(5, 400);
      `CHK((cyc >= (16 << r) - 4) && (cyc <= (20 << r) + 4), 1'b1)
    end
    ps = GCT_PS_DIV1;
    ge = 1;
    hold(1, 40);
    gi = 1;
    run(3, 100);
    gs = 0;
    gi = 0;
    // Both comparator paths, in random order; the synced copy lags by one count clock
    for (int k = 0; k < 2; k++) begin
      cse = (k == 0) ? 1'($urandom) : !cse;
      cmp = 1;
      run(3, 100);
      cmp = 0;
      // Let the synced copy see the low level before the gate is expected shut
      repeat (8) @(negedge clk);
      hold(1, 40);
      `CHK(cgs, 1'b0)
    end
    ge = 0;
    wr(1, 8'hFF);
    wr(0, 8'hFE);
    run(1, 50);
    `CHK(oflag, 1'b0)
    run(1, 50);
    `CHK(oflag, 1'b1)
    `CHK(woke, 1'b0)
    oclr = 1;
    @(negedge clk);
    oclr = 0;
    `CHK(oflag, 1'b0)
    cs = 1;
    fork ext.pulses(3); join_none
    run(3, 200);
    slp = 1;
    wr(1, 8'hFF);
    wr(0, 8'hFE);
    fork ext.pulses(3); join_none
    hold(1, 80);
    byp = 1;
    fork ext.pulses(3); join_none
    run(3, 200);
    `CHK(woke, 1'b1)
    final_report();
  end
endmodule : tb_gct_timer
`default_nettype wire
